// *** src/xbtr_regs.vh ***
// Purpose: Constants for the XIP boot and training read control block.
// Assumes: Configuration locations are reached through an internal write port.
// Notes:   Definitions only.
`ifndef XBTR_REGS_VH
`define XBTR_REGS_VH
`define XBTR_ADDR_BOOT_XIP      8'h06
`define XBTR_ADDR_PATTERN       8'h0a
`define XBTR_ADDR_OPTIONS       8'h0b
`define XBTR_RST_BOOT_XIP       8'hff
`define XBTR_RST_PATTERN        8'h55
`define XBTR_RST_OPTIONS        8'h40
`define XBTR_XIP_FAST           8'hf8
`define XBTR_XIP_OCT_OUT        8'hfd
`define XBTR_XIP_OCT_IO         8'hfe
`define XBTR_XIP_OFF            8'hff
`define XBTR_CMD_TRAIN          8'hcd
`define XBTR_CMD_RDSR           8'h05
`define XBTR_CMD_RDFSR          8'h70
`define XBTR_CMD_RSTEN          8'h66
`define XBTR_CMD_RSTMEM         8'h99
`define XBTR_SSO_BIT            6
`define XBTR_DQ_INV_LANE        3
`define XBTR_DUMMY_EXTRA        5'h02
`define XBTR_DUMMY_DEFAULT      5'h10
`define XBTR_VSL_NS             300000
`define XBTR_CLK_NS             25
`endif

// *** src/xbtr_ctrl.v ***
// Purpose: Read-mode control of an octal serial flash: XIP boot and exit, power-up gating, training read.
// Assumes: core_clk_in is the host serial clock; cs_n_in and DQ inputs are synchronous to it.
// Notes:   One DQ transfer per clock is modelled; DDR data are given as one byte per clock across all eight lanes.
`timescale 1ns/1ps
`include "xbtr_regs.vh"

// Behaviour
// - Boot XIP byte enabling XIP makes device start in XIP, address-only reads.
// - DQ0 in first dummy clock: 0 keeps XIP, 1 ends it.
// - DQ7..DQ1 are ignored in the first dummy clock.
// - XIP byte value F8h, FDh, FEh selects fast, octal output, octal I/O read.
// - Reset pin low clears XIP and reloads nonvolatile power-up state.
// - Forced exit only ends XIP, no reset, no abort of program/erase.
// - Below power-on threshold logic held in reset, all instructions ignored.
// - During power-up only status and flag status reads are accepted; XIP address-only reads are also started.
// - After power-up: standby, write latch, busy, lock bits all zero.
// - Controller-ready bit shows 0 while busy, 1 when done; host polls.
// - During power-up delay, default drive strength and strobe disabled.
// - Extended mode training read: CDh single-rate on DQ0, DDR data on all DQ.
// - Octal DDR training read: CDh twice as command, DDR data on all DQ.
// - Strobe is driven throughout every training read.
// - Training dummy count equals configured dummy count plus 2, default 18.
// - Pattern beats output 7 down to 0, repeating until chip select rises.
// - Pattern comes from register 0Ah, default 55h, writable.
// - Options bit 6 = 0 inverts the pattern on DQ3 only.
// - With XIP active each selection is decoded from address alone.
// - Confirmation bit of 1 sets the volatile XIP byte to FFh.
module xbtr_ctrl #(
  parameter integer VSL_CYCLES = (`XBTR_VSL_NS + `XBTR_CLK_NS - 1) / `XBTR_CLK_NS,
  parameter integer ADDR_CLKS  = 4
) (
  input  wire       core_clk_in,
  input  wire       arst_n_in,
  input  wire       por_n_in,
  input  wire       reset_pin_n_in,
  input  wire       octal_ddr_in,
  input  wire [4:0] dummy_cfg_in,
  input  wire       cs_n_in,
  input  wire [7:0] dq_in,
  input  wire       cfg_we_in,
  input  wire [7:0] cfg_addr_in,
  input  wire [7:0] cfg_wdata_in,
  input  wire       pe_busy_in,
  output reg  [7:0] dq_out,
  output reg  [7:0] dq_oe_out,
  output reg        dqs_out,
  output reg        dqs_oe_out,
  output reg        xip_active_out,
  output reg  [7:0] xip_vol_out,
  output reg  [1:0] xip_mode_out,
  output reg        read_start_out,
  output reg  [7:0] cmd_out,
  output reg        cmd_valid_out,
  output reg        pe_ready_out,
  output reg        wel_out,
  output reg        wip_out,
  output reg  [1:0] lock_out,
  output reg        powerup_busy_out,
  output reg        drive_default_out,
  output reg        sw_reset_out
);

  localparam [5:0] ST_IDLE  = 6'h01;
  localparam [5:0] ST_CMD   = 6'h02;
  localparam [5:0] ST_ADDR  = 6'h04;
  localparam [5:0] ST_DUMMY = 6'h08;
  localparam [5:0] ST_TRAIN = 6'h10;
  localparam [5:0] ST_SKIP  = 6'h20;

  // Maps an XIP configuration value to a read type; 0 means XIP disabled.
  function [1:0] xip_type;
    input [7:0] v;
    begin
      case (v)
        `XBTR_XIP_FAST:    xip_type = 2'h1;
        `XBTR_XIP_OCT_OUT: xip_type = 2'h2;
        `XBTR_XIP_OCT_IO:  xip_type = 2'h3;
        default:           xip_type = 2'h0;
      endcase
    end
  endfunction

  reg  [7:0]  nv_xip_reg;
  reg  [7:0]  pattern_reg;
  reg  [7:0]  options_reg;
  reg  [5:0]  state_reg;
  reg  [5:0]  state_next;
  reg  [7:0]  shift_reg;
  reg  [3:0]  bitcnt_reg;
  reg  [5:0]  cnt_reg;
  reg  [2:0]  beat_reg;
  reg         second_reg;
  reg         cs_q_reg;
  reg  [31:0] vsl_cnt_reg;
  reg         boot_pending_reg;
  reg         rsten_reg;
  reg  [5:0]  sel_len_reg;
  reg         dq0_all_reg;
  reg  [4:0]  seq_reg;
  wire [7:0]  dq_bits;
  reg  [7:0]  cmd_byte;

  wire        rst_any   = !arst_n_in || !por_n_in;
  wire        cs_fall   = cs_q_reg && !cs_n_in;
  wire        cs_rise   = !cs_q_reg && cs_n_in;
  // One spare bit keeps a large dummy setting from wrapping to a short count.
  wire [5:0]  train_dummy = {1'b0, dummy_cfg_in} + {1'b0, `XBTR_DUMMY_EXTRA};
  wire        inv_dq3   = !options_reg[`XBTR_SSO_BIT];
  wire        pat_bit   = pattern_reg[beat_reg];

  always @* begin
    cmd_byte = octal_ddr_in ? dq_in : {shift_reg[6:0], dq_in[0]};
  end

  // Pattern lanes, with lane 3 optionally inverted for switching-noise training.
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_lane
      if (g == `XBTR_DQ_INV_LANE) begin : g_inv
        assign dq_bits[g] = pat_bit ^ inv_dq3;
      end else begin : g_same
        assign dq_bits[g] = pat_bit;
      end
    end
  endgenerate

  always @* begin
    state_next = state_reg;
    if (cs_n_in) begin
      state_next = ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (cs_fall) begin
            state_next = xip_active_out ? ST_ADDR : ST_CMD;
          end
        end
        ST_CMD: begin
          if (octal_ddr_in ? (second_reg && dq_in == `XBTR_CMD_TRAIN)
                           : (bitcnt_reg == 4'h7 && cmd_byte == `XBTR_CMD_TRAIN)) begin
            state_next = powerup_busy_out ? ST_SKIP : ST_DUMMY;
          end else if (octal_ddr_in ? second_reg : (bitcnt_reg == 4'h7)) begin
            state_next = ST_SKIP;
          end
        end
        ST_ADDR: begin
          if (cnt_reg == ADDR_CLKS[5:0] - 6'h01) begin
            state_next = ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          if (!xip_active_out && cnt_reg == train_dummy - 6'h01) begin
            state_next = ST_TRAIN;
          end else if (xip_active_out) begin
            state_next = ST_SKIP;
          end
        end
        ST_TRAIN: state_next = ST_TRAIN;
        ST_SKIP:  state_next = ST_SKIP;
        default:  state_next = ST_IDLE;
      endcase
    end
  end

  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      nv_xip_reg  <= `XBTR_RST_BOOT_XIP;
      pattern_reg <= `XBTR_RST_PATTERN;
      options_reg <= `XBTR_RST_OPTIONS;
    end else if (cfg_we_in && !powerup_busy_out) begin
      if (cfg_addr_in == `XBTR_ADDR_BOOT_XIP) begin
        nv_xip_reg <= cfg_wdata_in;
      end
      if (cfg_addr_in == `XBTR_ADDR_PATTERN) begin
        pattern_reg <= cfg_wdata_in;
      end
      if (cfg_addr_in == `XBTR_ADDR_OPTIONS) begin
        options_reg <= cfg_wdata_in;
      end
    end
  end

  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg         <= ST_IDLE;
      shift_reg         <= 8'h00;
      bitcnt_reg        <= 4'h0;
      cnt_reg           <= 6'h00;
      beat_reg          <= 3'h7;
      second_reg        <= 1'b0;
      cs_q_reg          <= 1'b1;
      vsl_cnt_reg       <= 32'h0;
      boot_pending_reg  <= 1'b1;
      rsten_reg         <= 1'b0;
      sel_len_reg       <= 6'h00;
      dq0_all_reg       <= 1'b1;
      seq_reg           <= 5'h00;
      dq_out            <= 8'h00;
      dq_oe_out         <= 8'h00;
      dqs_out           <= 1'b0;
      dqs_oe_out        <= 1'b0;
      xip_active_out    <= 1'b0;
      xip_vol_out       <= `XBTR_XIP_OFF;
      xip_mode_out      <= 2'h0;
      read_start_out    <= 1'b0;
      cmd_out           <= 8'h00;
      cmd_valid_out     <= 1'b0;
      pe_ready_out      <= 1'b1;
      wel_out           <= 1'b0;
      wip_out           <= 1'b0;
      lock_out          <= 2'h0;
      powerup_busy_out  <= 1'b1;
      drive_default_out <= 1'b1;
      sw_reset_out      <= 1'b0;
    end else if (rst_any || !reset_pin_n_in) begin
      // Power-on or pin reset: XIP cleared, reload from nonvolatile byte on release.
      state_reg         <= ST_IDLE;
      xip_active_out    <= 1'b0;
      boot_pending_reg  <= 1'b1;
      dq_oe_out         <= 8'h00;
      dqs_oe_out        <= 1'b0;
      cmd_valid_out     <= 1'b0;
      read_start_out    <= 1'b0;
      cs_q_reg          <= 1'b1;
      seq_reg           <= 5'h00;
      if (rst_any) begin
        vsl_cnt_reg       <= 32'h0;
        powerup_busy_out  <= 1'b1;
        drive_default_out <= 1'b1;
        wel_out           <= 1'b0;
        wip_out           <= 1'b0;
        lock_out          <= 2'h0;
      end
    end else begin
      state_reg      <= state_next;
      cs_q_reg       <= cs_n_in;
      cmd_valid_out  <= 1'b0;
      read_start_out <= 1'b0;
      sw_reset_out   <= 1'b0;
      pe_ready_out   <= !pe_busy_in;
      wip_out        <= pe_busy_in;
      // Until this count expires only the status reads and the XIP address-only reads get through.
      if (powerup_busy_out) begin
        if (vsl_cnt_reg == VSL_CYCLES - 1) begin
          powerup_busy_out  <= 1'b0;
          drive_default_out <= 1'b0;
        end else begin
          vsl_cnt_reg <= vsl_cnt_reg + 32'h1;
        end
      end
      // The nonvolatile byte is copied on the first clock after any reset is released.
      if (boot_pending_reg) begin
        boot_pending_reg <= 1'b0;
        xip_vol_out      <= nv_xip_reg;
        xip_mode_out     <= xip_type(nv_xip_reg);
        xip_active_out   <= (xip_type(nv_xip_reg) != 2'h0);
      end
      if (cs_fall) begin
        bitcnt_reg  <= 4'h0;
        cnt_reg     <= 6'h00;
        second_reg  <= 1'b0;
        beat_reg    <= 3'h7;
      end
      if (!cs_n_in) begin
        // The first low clock of a selection restarts the length and the DQ0 record.
        if (cs_fall) begin
          sel_len_reg <= 6'h01;
          dq0_all_reg <= dq_in[0];
        end else begin
          if (sel_len_reg != 6'h3f) begin
            sel_len_reg <= sel_len_reg + 6'h01;
          end
          dq0_all_reg <= dq0_all_reg & dq_in[0];
        end
      end
      if (cs_rise) begin
        // Forced exit sequence: selections of 3,4,5,25,33 clocks with DQ0 high.
        if (dq0_all_reg && ((seq_reg == 5'h00 && sel_len_reg == 6'd3) ||
                            (seq_reg == 5'h01 && sel_len_reg == 6'd4) ||
                            (seq_reg == 5'h03 && sel_len_reg == 6'd5) ||
                            (seq_reg == 5'h07 && sel_len_reg == 6'd25))) begin
          seq_reg <= {seq_reg[3:0], 1'b1};
        end else if (dq0_all_reg && seq_reg == 5'h0f && sel_len_reg == 6'd33) begin
          seq_reg        <= 5'h00;
          xip_active_out <= 1'b0;
          xip_vol_out    <= `XBTR_XIP_OFF;
        end else begin
          seq_reg <= 5'h00;
        end
        dq_oe_out  <= 8'h00;
        dqs_oe_out <= 1'b0;
      end
      // Nothing advances while deselected, so the chip-select release clears the drivers.
      case (cs_n_in ? ST_IDLE : state_reg)
        ST_CMD: begin
          shift_reg  <= cmd_byte;
          bitcnt_reg <= bitcnt_reg + 4'h1;
          second_reg <= 1'b1;
          if (octal_ddr_in ? second_reg : (bitcnt_reg == 4'h7)) begin
            if (!powerup_busy_out || cmd_byte == `XBTR_CMD_RDSR || cmd_byte == `XBTR_CMD_RDFSR) begin
              cmd_out       <= cmd_byte;
              cmd_valid_out <= (cmd_byte != `XBTR_CMD_TRAIN);
              rsten_reg     <= (cmd_byte == `XBTR_CMD_RSTEN);
              sw_reset_out  <= rsten_reg && (cmd_byte == `XBTR_CMD_RSTMEM);
            end
          end
        end
        ST_ADDR: begin
          cnt_reg <= (state_next == ST_DUMMY) ? 6'h00 : cnt_reg + 6'h01;
        end
        ST_DUMMY: begin
          cnt_reg <= cnt_reg + 6'h01;
          // The strobe is enabled ahead of the first training beat.
          dqs_oe_out <= !xip_active_out;
          if (xip_active_out) begin
            // Only DQ0 counts here; upper lanes are don't care.
            read_start_out <= 1'b1;
            // A confirmation bit of 1 drops XIP for the selections that follow.
            if (dq_in[0]) begin
              xip_active_out <= 1'b0;
              xip_vol_out    <= `XBTR_XIP_OFF;
            end
          end
        end
        ST_TRAIN: begin
          dq_out     <= dq_bits;
          dq_oe_out  <= 8'hff;
          dqs_out    <= ~dqs_out;
          dqs_oe_out <= 1'b1;
          // The three-bit beat count wraps from 0 back to 7 by itself.
          beat_reg   <= beat_reg - 3'h1;
        end
        default: begin
        end
      endcase
    end
  end

endmodule

// *** testbench/xbtr_ctrl_monitor.sv ***
// Purpose: Port assertions for xbtr_ctrl.
// Assumes: Outputs are registered on core_clk_in.
// Notes:   Bound to every xbtr_ctrl instance.
`timescale 1ns/1ps
module xbtr_ctrl_monitor (
  input wire       core_clk_in,
  input wire       arst_n_in,
  input wire       por_n_in,
  input wire       reset_pin_n_in,
  input wire       cs_n_in,
  input wire       pe_busy_in,
  input wire [7:0] dq_oe_out,
  input wire       dqs_oe_out,
  input wire       xip_active_out,
  input wire [7:0] xip_vol_out,
  input wire [7:0] cmd_out,
  input wire       cmd_valid_out,
  input wire       pe_ready_out,
  input wire       powerup_busy_out,
  input wire       drive_default_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_idle; cs_n_in [*2]; endsequence
  sequence s_train; dq_oe_out == 8'hff; endsequence
  property p_ready; pe_busy_in |-> ##[1:2] !pe_ready_out; endproperty
  a_ready: assert property (p_ready) else $error("ready while busy");
  property p_por; !por_n_in |=> dq_oe_out == 8'h00 && !xip_active_out; endproperty
  a_por: assert property (p_por) else $error("active under power-on reset");
  property p_pin; !reset_pin_n_in |=> !xip_active_out; endproperty
  a_pin: assert property (p_pin) else $error("xip kept over reset pin");
  property p_vsl; powerup_busy_out |-> drive_default_out && !dqs_oe_out; endproperty
  a_vsl: assert property (p_vsl) else $error("strobe or drive wrong in power-up");
  property p_train; s_train |-> dqs_oe_out; endproperty
  a_train: assert property (p_train) else $error("strobe off during pattern");
  property p_idle; s_idle |-> dq_oe_out == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("driving while deselected");
  property p_exit;
    $fell(xip_active_out) && $past(reset_pin_n_in) && $past(por_n_in) |-> ##[0:1] xip_vol_out == 8'hff;
  endproperty
  a_exit: assert property (p_exit) else $error("volatile xip byte not cleared");
  property p_refuse; cmd_valid_out && powerup_busy_out |-> cmd_out == 8'h05 || cmd_out == 8'h70; endproperty
  a_refuse: assert property (p_refuse) else $error("command taken in power-up");
endmodule
bind xbtr_ctrl xbtr_ctrl_monitor xbtr_ctrl_monitor_inst (
  .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .por_n_in(por_n_in), .reset_pin_n_in(reset_pin_n_in),
  .cs_n_in(cs_n_in), .pe_busy_in(pe_busy_in), .dq_oe_out(dq_oe_out), .dqs_oe_out(dqs_oe_out),
  .xip_active_out(xip_active_out), .xip_vol_out(xip_vol_out), .cmd_out(cmd_out), .cmd_valid_out(cmd_valid_out),
  .pe_ready_out(pe_ready_out), .powerup_busy_out(powerup_busy_out), .drive_default_out(drive_default_out));

// *** testbench/xbtr_host_model.sv ***
// Purpose: Host controller model that frames selections.
// Assumes: One DQ value per clock while selected.
// Notes:   Released lines show the inverse of the last value.
`timescale 1ns/1ps
module xbtr_host_model (
  input  wire       core_clk_in,
  output reg        cs_n_out = 1'b1,
  output reg  [7:0] dq_out = 8'h5a
);
  // Chip select rises on the clock after the last value, once that value has been sampled.
  task sel(input logic [7:0] q[$]);
    integer i;
    begin
      for (i = 0; i < q.size(); i = i + 1) begin
        @(posedge core_clk_in);
        cs_n_out <= 1'b0;
        dq_out <= q[i];
      end
      @(posedge core_clk_in);
      cs_n_out <= 1'b1;
      dq_out <= ~q[q.size() - 1];
      @(posedge core_clk_in);
    end
  endtask
endmodule

// *** testbench/xbtr_ctrl_tb.sv ***
// Purpose: Self-checking bench for xbtr_ctrl.
// Assumes: A lead clock precedes every command; one beat per clock.
// Notes:   Power-up delay shortened to 40 clocks.
`timescale 1ns/1ps
module xbtr_ctrl_tb;
  reg        core_clk_in, arst_n_in, por_n_in, reset_pin_n_in, octal_ddr_in, cfg_we_in, pe_busy_in, dqs_p;
  reg  [4:0] dummy_cfg_in;
  reg  [7:0] cfg_addr_in, cfg_wdata_in, pat_m, opt_m, last_cmd, rv, oe_p;
  wire       cs_n, xip_act, rd_go, cmd_vld, ready, wel, wip, pu_busy, swr, dqs;
  wire [7:0] dq, dq_o, dq_oe, vol, cmd;
  wire [1:0] mode, lock;
  integer    n_fail, n_compared, seed, beat, n_beats, n_cmd, n_rd, n_swr, cyc, k, t;
  logic [7:0] q[$];
  xbtr_ctrl #(.VSL_CYCLES(40), .ADDR_CLKS(4)) xbtr_ctrl_inst (
    .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .por_n_in(por_n_in), .reset_pin_n_in(reset_pin_n_in),
    .octal_ddr_in(octal_ddr_in), .dummy_cfg_in(dummy_cfg_in), .cs_n_in(cs_n), .dq_in(dq), .cfg_we_in(cfg_we_in),
    .cfg_addr_in(cfg_addr_in), .cfg_wdata_in(cfg_wdata_in), .pe_busy_in(pe_busy_in), .dq_out(dq_o),
    .dq_oe_out(dq_oe), .dqs_out(dqs), .dqs_oe_out(), .xip_active_out(xip_act), .xip_vol_out(vol),
    .xip_mode_out(mode), .read_start_out(rd_go), .cmd_out(cmd), .cmd_valid_out(cmd_vld), .pe_ready_out(ready),
    .wel_out(wel), .wip_out(wip), .lock_out(lock), .powerup_busy_out(pu_busy), .drive_default_out(),
    .sw_reset_out(swr));
  xbtr_host_model xbtr_host_model_inst (.core_clk_in(core_clk_in), .cs_n_out(cs_n), .dq_out(dq));
  initial begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end
  function automatic [7:0] r8();
    reg [31:0] v;
    begin
      v = $random(seed);
      r8 = v[7:0];
    end
  endfunction
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task close_out;
    begin
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task cfg(input [7:0] a, input [7:0] d);
    begin
      @(posedge core_clk_in);
      cfg_we_in <= 1'b1;
      cfg_addr_in <= a;
      cfg_wdata_in <= d;
      if (a == 8'h0a) pat_m = d;
      if (a == 8'h0b) opt_m = d;
      @(posedge core_clk_in);
      cfg_we_in <= 1'b0;
    end
  endtask
  // Extended mode sends the code on DQ0 only, octal DDR sends it twice on all lines.
  task send(input [7:0] c, input integer extra);
    integer j;
    begin
      q = {8'h00};
      if (octal_ddr_in) q = {8'h00, c, c};
      else for (j = 7; j >= 0; j = j - 1) q.push_back((r8() & 8'hfe) | {7'h00, c[j]});
      repeat (extra) q.push_back(r8());
      xbtr_host_model_inst.sel(q);
    end
  endtask
  // Every clock carries the confirmation value on DQ0 and noise elsewhere.
  task xip_read(input xb);
    begin
      q = {};
      repeat (7) q.push_back((r8() & 8'hfe) | {7'h00, xb});
      xbtr_host_model_inst.sel(q);
      repeat (2) @(posedge core_clk_in);
    end
  endtask
  task wait_ready;
    begin
      // One clock lets values launched at the caller's last edge settle.
      @(posedge core_clk_in);
      repeat (100) if (pu_busy !== 1'b0) @(posedge core_clk_in);
      chk({7'h00, pu_busy}, 8'h00);
    end
  endtask
  always @(posedge core_clk_in) begin
    cyc = cyc + 1;
    if (cmd_vld === 1'b1) begin
      n_cmd = n_cmd + 1;
      last_cmd = cmd;
    end
    if (rd_go === 1'b1) n_rd = n_rd + 1;
    if (swr === 1'b1) n_swr = n_swr + 1;
    if (cs_n !== 1'b0) beat = 7;
    else if (dq_oe === 8'hff) begin
      chk(dq_o, {8{pat_m[beat]}} ^ (opt_m[6] ? 8'h00 : 8'h08));
      if (oe_p === 8'hff) chk({7'h00, dqs}, {7'h00, ~dqs_p});
      n_beats = n_beats + 1;
      beat = (beat == 0) ? 7 : beat - 1;
    end
    dqs_p = dqs;
    oe_p = dq_oe;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      close_out;
    end
  end
  initial begin
    {arst_n_in, por_n_in, octal_ddr_in, cfg_we_in, pe_busy_in} = 5'h00;
    {reset_pin_n_in, dummy_cfg_in, cfg_addr_in, cfg_wdata_in} = {1'b1, 5'h10, 16'h0000};
    {pat_m, opt_m, last_cmd} = 24'h554000;
    {n_fail, n_compared, beat, n_beats, n_cmd, n_rd, n_swr, cyc, seed} = {256'h0, 32'd33};
    repeat (8) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    @(posedge core_clk_in);
    chk({ready, pu_busy, xip_act, 5'h00}, 8'hc0);
    chk(vol, 8'hff);
    send(8'h05, 2);
    chk(n_cmd[7:0], 8'h00);
    por_n_in <= 1'b1;
    send(8'h66, 2);
    chk(n_cmd[7:0], 8'h00);
    send(8'h05, 2);
    chk(last_cmd, 8'h05);
    wait_ready;
    chk({wel, wip, lock, 4'h0}, 8'h00);
    for (k = 0; k < 3; k = k + 1) begin
      cfg(8'h06, (k == 0) ? 8'hf8 : (k == 1) ? 8'hfd : 8'hfe);
      if (k == 2) por_n_in <= 1'b0;
      else reset_pin_n_in <= 1'b0;
      repeat (3) @(posedge core_clk_in);
      por_n_in <= 1'b1;
      reset_pin_n_in <= 1'b1;
      @(posedge core_clk_in);
      wait_ready;
      chk({7'h00, xip_act}, 8'h01);
      chk({6'h00, mode}, 8'h01 + k[7:0]);
      t = n_rd;
      xip_read(1'b0);
      chk(n_rd[7:0] - t[7:0], 8'h01);
      chk({7'h00, xip_act}, 8'h01);
      if (k < 2) begin
        xip_read(1'b1);
        chk({xip_act, 7'h00}, 8'h00);
        chk(vol, 8'hff);
      end else begin
        pe_busy_in <= 1'b1;
        for (t = 0; t < 5; t = t + 1) begin
          q = {};
          repeat ((t < 3) ? t + 3 : 8 * t + 1) q.push_back(r8() | 8'h01);
          xbtr_host_model_inst.sel(q);
        end
        chk({xip_act, ready, pu_busy, 5'h00}, 8'h00);
        pe_busy_in <= 1'b0;
        repeat (3) @(posedge core_clk_in);
        chk({7'h00, ready}, 8'h01);
        cfg(8'h06, 8'hff);
        t = n_swr;
        send(8'h66, 2);
        send(8'h99, 4);
        chk(n_swr[7:0] - t[7:0], 8'h01);
        wait_ready;
        if (xip_act === 1'b1) xip_read(1'b1);
      end
    end
    for (k = 0; k < 3; k = k + 1) begin
      rv = r8();
      if (k == 1) cfg(8'h0a, r8());
      cfg(8'h0b, (k == 1) ? 8'h00 : 8'h40);
      octal_ddr_in <= (k == 2);
      dummy_cfg_in <= (k == 0) ? 5'h10 : {1'b0, rv[3:0]};
      @(posedge core_clk_in);
      n_beats = 0;
      send(8'hcd, 40);
      // Dummy clocks are the setting plus two; the beat launched as chip select rises is not seen.
      t = 40 - (dummy_cfg_in + 2) - 1;
      chk(n_beats[7:0], t[7:0]);
    end
    close_out;
  end
endmodule
